// >>> src/pmwc_pkg.sv
// Package for the power-mode and wake-up controller.
// Assumes one clock (main oscillator domain) and an asynchronous active-high reset.
package pmwc_pkg;

  // ==========================================================================
  // Power modes
  typedef enum logic [2:0] {
    PMWC_RUN       = 3'b000,
    PMWC_SLOW      = 3'b001,
    PMWC_WAIT      = 3'b010,
    PMWC_SLOW_WAIT = 3'b011,
    PMWC_HALT      = 3'b100,
    PMWC_ACT_HALT  = 3'b101,
    PMWC_STARTUP   = 3'b110
  } pmwc_mode_e;

  // ==========================================================================
  // Clock division (log2 of divide ratio)
  localparam logic [2:0] PMWC_DIV_NORMAL_LOG2 = 3'h1;  // Divide by 2
  localparam logic [2:0] PMWC_DIV_SLOW_BASE   = 3'h2;  // Field 0 means divide by 4
  localparam int         PMWC_DIV_CNT_W       = 5;

  // ==========================================================================
  // Startup delay in CPU cycles
  localparam int PMWC_STARTUP_CYCLES = 4096;
  localparam int PMWC_STARTUP_W      = 13;

  // ==========================================================================
  // Interrupt sources, indexed by their number
  localparam int PMWC_NSRC = 14;
  localparam logic [PMWC_NSRC-1:0] PMWC_USED_MASK      = 14'h0fbe;
  localparam logic [PMWC_NSRC-1:0] PMWC_WAKE_HALT_MASK = 14'h003c;
  localparam logic [PMWC_NSRC-1:0] PMWC_WAKE_AHLT_MASK = 14'h003e;
  localparam int PMWC_SRC_TIMEBASE = 1;

  // ==========================================================================
  // Vector addresses (high byte address of each pair is this plus one)
  localparam logic [15:0] PMWC_VEC_RESET = 16'hfffe;
  localparam logic [15:0] PMWC_VEC_TRAP  = 16'hfffc;
  localparam logic [15:0] PMWC_VEC_SRC0  = 16'hfffa;
  localparam logic [15:0] PMWC_VEC_STEP  = 16'h0002;

endpackage

// >>> src/pmwc_controller.sv
// Power-mode and wake-up controller: run, slow, wait, halt and timed-standby halt,
// plus the fixed-priority vector and wake map.
// Assumes the CPU core pulses the instruction strobes and consumes the vector grant.
`timescale 1ns/1ps

module pmwc_controller #(
  parameter int STARTUP_CYCLES = pmwc_pkg::PMWC_STARTUP_CYCLES
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          slow_select,
  input  wire logic [1:0]                    slow_divider_field,
  input  wire logic                          oscillator_irq_enable,
  input  wire logic                          watchdog_halt_option,
  input  wire logic                          watchdog_enabled,
  input  wire logic                          wait_for_irq_instr,
  input  wire logic                          halt_instr,
  input  wire logic                          trap_instr,
  input  wire logic                          irq_ack,
  input  wire logic                          cc_push,
  input  wire logic                          cc_pop,
  input  wire logic                          cc_mask_set,
  input  wire logic                          cc_mask_clr,
  input  wire logic                          timebase_irq,
  input  wire logic                          clock_security_irq,
  input  wire logic [3:0]                    ext_irq_group,
  input  wire logic [4:0]                    periph_irq,
  output logic                               cpu_clk_en,
  output logic                               periph_clk_en,
  output logic                               osc_enable,
  output logic                               cpu_stopped,
  output logic [2:0]                         power_mode,
  output logic                               irq_mask,
  output logic                               irq_request,
  output logic [15:0]                        irq_vector,
  output logic                               watchdog_reset_req,
  output logic                               shared_src_timebase,
  output logic                               shared_src_security
);

  localparam int NSRC = pmwc_pkg::PMWC_NSRC;
  localparam int SW   = pmwc_pkg::PMWC_STARTUP_W;

  // ==========================================================================
  // State
  pmwc_pkg::pmwc_mode_e mode_r, mode_nxt;
  logic [pmwc_pkg::PMWC_DIV_CNT_W-1:0] div_cnt_r;
  logic [SW-1:0]   start_cnt_r;
  logic            mask_r;
  logic            mask_saved_r;
  logic            start_reset_r;
  logic            cpu_clk_en_r, periph_clk_en_r, osc_enable_r;
  logic            cpu_stopped_r;
  logic            irq_request_r, wdg_reset_r;
  logic [15:0]     irq_vector_r;
  logic            sh_tb_r, sh_css_r;
  logic            trap_pend_r;

  // ==========================================================================
  // Source collection, numbered as in the vector map
  wire [NSRC-1:0] src_raw;
  assign src_raw = {2'b00, periph_irq, 1'b0, ext_irq_group,
                    timebase_irq | clock_security_irq, 1'b0};
  wire [NSRC-1:0] src_live = src_raw & pmwc_pkg::PMWC_USED_MASK;

  // Wake eligibility per halt variant
  wire [NSRC-1:0] wake_halt = src_live & pmwc_pkg::PMWC_WAKE_HALT_MASK;
  wire [NSRC-1:0] wake_ahlt = src_live & pmwc_pkg::PMWC_WAKE_AHLT_MASK;
  wire            any_src   = |src_live;

  // Lowest numbered pending source wins
  logic [3:0] win_idx;
  always_comb begin
    win_idx = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (src_live[i]) begin
        win_idx = 4'(i);
      end
    end
  end

  wire [15:0] src_vec = pmwc_pkg::PMWC_VEC_SRC0 - 16'(win_idx) * pmwc_pkg::PMWC_VEC_STEP;

  // ==========================================================================
  // Clock divider
  wire [2:0] div_log2 = (slow_select == 1'b1)
                        ? pmwc_pkg::PMWC_DIV_SLOW_BASE + {1'b0, slow_divider_field}
                        : pmwc_pkg::PMWC_DIV_NORMAL_LOG2;
  wire [pmwc_pkg::PMWC_DIV_CNT_W-1:0] div_top =
    pmwc_pkg::PMWC_DIV_CNT_W'((32'h1 << div_log2) - 32'h1);
  wire div_tick = (div_cnt_r >= div_top);

  // ==========================================================================
  // Mode transitions
  wire in_halt   = (mode_r == pmwc_pkg::PMWC_HALT);
  wire in_ahlt   = (mode_r == pmwc_pkg::PMWC_ACT_HALT);
  wire in_wait   = (mode_r == pmwc_pkg::PMWC_WAIT) || (mode_r == pmwc_pkg::PMWC_SLOW_WAIT);
  wire in_active = (mode_r == pmwc_pkg::PMWC_RUN) || (mode_r == pmwc_pkg::PMWC_SLOW);
  wire start_done = (start_cnt_r == SW'(STARTUP_CYCLES - 1)) && div_tick;

  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      pmwc_pkg::PMWC_RUN, pmwc_pkg::PMWC_SLOW: begin
        if (wait_for_irq_instr) begin
          mode_nxt = slow_select ? pmwc_pkg::PMWC_SLOW_WAIT : pmwc_pkg::PMWC_WAIT;
        end else if (halt_instr) begin
          mode_nxt = oscillator_irq_enable ? pmwc_pkg::PMWC_ACT_HALT
                                           : pmwc_pkg::PMWC_HALT;
        end else begin
          mode_nxt = slow_select ? pmwc_pkg::PMWC_SLOW : pmwc_pkg::PMWC_RUN;
        end
      end
      pmwc_pkg::PMWC_WAIT, pmwc_pkg::PMWC_SLOW_WAIT: begin
        if (any_src) begin
          mode_nxt = slow_select ? pmwc_pkg::PMWC_SLOW : pmwc_pkg::PMWC_RUN;
        end
      end
      pmwc_pkg::PMWC_HALT: begin
        if (|wake_halt) begin
          mode_nxt = pmwc_pkg::PMWC_STARTUP;
        end
      end
      pmwc_pkg::PMWC_ACT_HALT: begin
        if (|wake_ahlt) begin
          mode_nxt = pmwc_pkg::PMWC_STARTUP;
        end
      end
      pmwc_pkg::PMWC_STARTUP: begin
        if (start_done) begin
          mode_nxt = slow_select ? pmwc_pkg::PMWC_SLOW : pmwc_pkg::PMWC_RUN;
        end
      end
      default: mode_nxt = pmwc_pkg::PMWC_RUN;
    endcase
  end

  // Next-mode decode for grants, clock gates and the stop flag
  wire nxt_active    = (mode_nxt == pmwc_pkg::PMWC_RUN) || (mode_nxt == pmwc_pkg::PMWC_SLOW);
  wire nxt_unclocked = (mode_nxt == pmwc_pkg::PMWC_HALT) ||
                       (mode_nxt == pmwc_pkg::PMWC_ACT_HALT) ||
                       (mode_nxt == pmwc_pkg::PMWC_STARTUP);
  wire nxt_osc_off   = (mode_nxt == pmwc_pkg::PMWC_HALT);

  // Wake restarts the divider so the startup delay is whole CPU cycles
  wire wake_start = (mode_nxt == pmwc_pkg::PMWC_STARTUP) && (mode_r != pmwc_pkg::PMWC_STARTUP);

  // Halt with watchdog running resets unless timed-standby or the option allows it
  wire halt_wdg = in_active && halt_instr && !wait_for_irq_instr && watchdog_enabled &&
                  !oscillator_irq_enable && !watchdog_halt_option;

  // Grant to the CPU when running with the mask clear; trap ignores the mask
  wire grant_src  = nxt_active && !mask_r && any_src && !irq_request_r && !start_reset_r;
  wire grant_trap = trap_pend_r && in_active && !irq_request_r && !start_reset_r;
  wire entering_low = in_active && (wait_for_irq_instr || halt_instr);

  // ==========================================================================
  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_r <= pmwc_pkg::PMWC_RUN;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_r <= '0;
    end else begin
      div_cnt_r <= (div_tick || wake_start) ? '0 : div_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_cnt_r <= '0;
    end else if (mode_r == pmwc_pkg::PMWC_STARTUP) begin
      start_cnt_r <= start_cnt_r + SW'(div_tick);
    end else begin
      start_cnt_r <= '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_reset_r <= 1'b1;
    end else if (in_active) begin
      start_reset_r <= 1'b0;
    end
  end

  // Global mask: set after reset, cleared on low-power entry, saved and restored on service
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mask_r       <= 1'b1;
      mask_saved_r <= 1'b1;
    end else begin
      if (entering_low) begin
        mask_r <= 1'b0;
      end else if (cc_push || irq_ack) begin
        mask_saved_r <= mask_r;
        mask_r       <= 1'b1;
      end else if (cc_pop) begin
        mask_r <= mask_saved_r;
      end else if (cc_mask_set) begin
        mask_r <= 1'b1;
      end else if (cc_mask_clr) begin
        mask_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trap_pend_r <= 1'b0;
    end else if (trap_instr) begin
      trap_pend_r <= 1'b1;
    end else if (grant_trap) begin
      trap_pend_r <= 1'b0;
    end
  end

  // Request stands until the CPU acknowledges it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_request_r <= 1'b0;
    end else if (irq_ack) begin
      irq_request_r <= 1'b0;
    end else if (grant_trap || grant_src) begin
      irq_request_r <= 1'b1;
    end
  end

  // Reset vector stands until the first grant replaces it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_vector_r <= pmwc_pkg::PMWC_VEC_RESET;
    end else if (start_reset_r) begin
      irq_vector_r <= pmwc_pkg::PMWC_VEC_RESET;
    end else if (grant_trap) begin
      irq_vector_r <= pmwc_pkg::PMWC_VEC_TRAP;
    end else if (grant_src) begin
      irq_vector_r <= src_vec;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sh_tb_r  <= 1'b0;
      sh_css_r <= 1'b0;
    end else begin
      sh_tb_r  <= timebase_irq;
      sh_css_r <= clock_security_irq;
    end
  end

  // Clock gating per mode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_clk_en_r    <= 1'b0;
      periph_clk_en_r <= 1'b0;
      osc_enable_r    <= 1'b1;
    end else begin
      cpu_clk_en_r    <= div_tick && nxt_active;
      periph_clk_en_r <= div_tick && !nxt_unclocked;
      osc_enable_r    <= !nxt_osc_off;
    end
  end

  // CPU stop flag follows the mode register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_stopped_r <= 1'b0;
    end else begin
      cpu_stopped_r <= !nxt_active;
    end
  end

  // Watchdog reset request, one cycle per offending halt
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wdg_reset_r <= 1'b0;
    end else begin
      wdg_reset_r <= halt_wdg;
    end
  end

  // ==========================================================================
  // Outputs
  assign cpu_clk_en          = cpu_clk_en_r;
  assign periph_clk_en       = periph_clk_en_r;
  assign osc_enable          = osc_enable_r;
  assign cpu_stopped         = cpu_stopped_r;
  assign power_mode          = mode_r;
  assign irq_mask            = mask_r;
  assign irq_request         = irq_request_r;
  assign irq_vector          = irq_vector_r;
  assign watchdog_reset_req  = wdg_reset_r;
  assign shared_src_timebase = sh_tb_r;
  assign shared_src_security = sh_css_r;

  wire unused_ok = in_halt | in_ahlt | in_wait;

endmodule // pmwc_controller

// >>> test/pmwc_chk.sv
// Checker for mode, clock and wake relations of the power-mode controller.
// Assumes a bind onto pmwc_controller; one clock, async active-high reset.
`timescale 1ns/1ps
module pmwc_chk (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       wait_for_irq_instr,
  input wire logic       halt_instr,
  input wire logic       oscillator_irq_enable,
  input wire logic       irq_ack,
  input wire logic [3:0] ext_irq_group,
  input wire logic       cpu_clk_en,
  input wire logic       periph_clk_en,
  input wire logic       osc_enable,
  input wire logic       cpu_stopped,
  input wire logic [2:0] power_mode,
  input wire logic       irq_mask,
  input wire logic       watchdog_reset_req
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========
  // Properties
  property p_run_div;
    cpu_clk_en && power_mode == 3'h0 |=> !cpu_clk_en ##1 (cpu_clk_en || power_mode != 3'h0);
  endproperty
  a_run_div: assert property (p_run_div) else $error("run clock not divided by two");
  property p_wait;
    wait_for_irq_instr && power_mode == 3'h0 |=> power_mode == 3'h2 && !irq_mask;
  endproperty
  a_wait: assert property (p_wait) else $error("wait entry wrong");
  property p_slow_wait;
    wait_for_irq_instr && power_mode == 3'h1 |=> power_mode == 3'h3;
  endproperty
  a_slow_wait: assert property (p_slow_wait) else $error("slow wait entry wrong");
  property p_halt;
    halt_instr && !wait_for_irq_instr && power_mode == 3'h0
      |=> power_mode == ($past(oscillator_irq_enable) ? 3'h5 : 3'h4);
  endproperty
  a_halt: assert property (p_halt) else $error("halt variant wrong");
  property p_osc_off;
    power_mode == 3'h4 |-> !osc_enable;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator runs in full halt");
  property p_halt_clk;
    (power_mode[2:1] == 2'b10) [*2] |-> !periph_clk_en && !cpu_clk_en;
  endproperty
  a_halt_clk: assert property (p_halt_clk) else $error("clock pulse during halt");
  property p_no_wdog;
    halt_instr && oscillator_irq_enable && !power_mode[2] |=> !watchdog_reset_req [*2];
  endproperty
  a_no_wdog: assert property (p_no_wdog) else $error("watchdog reset on standby");
  property p_halt_hold;
    power_mode == 3'h4 && ext_irq_group == 4'h0 |=> power_mode == 3'h4;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("full halt left wrongly");
  property p_halt_wake;
    power_mode == 3'h4 && ext_irq_group != 4'h0 |=> power_mode == 3'h6;
  endproperty
  a_halt_wake: assert property (p_halt_wake) else $error("external group did not wake");
  property p_ack_mask;
    irq_ack |=> irq_mask;
  endproperty
  a_ack_mask: assert property (p_ack_mask) else $error("mask not set on entry");
  property p_stopped;
    cpu_stopped == (power_mode > 3'h1);
  endproperty
  a_stopped: assert property (p_stopped) else $error("cpu stop flag wrong");
  c_standby: cover property (power_mode == 3'h5);
  c_slow_wait: cover property (power_mode == 3'h3);
  c_startup: cover property (power_mode == 3'h6);
endmodule // pmwc_chk

// >>> test/pmwc_cpu_model.sv
// CPU side model: acknowledges each vector grant two cycles after it appears.
// Assumes the grant stands until acknowledged.
`timescale 1ns/1ps
module pmwc_cpu_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic irq_request,
  output logic      irq_ack
);
  // ==========
  // Acknowledge
  logic cnt_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r   <= 1'b0;
      irq_ack <= 1'b0;
    end else begin
      cnt_r   <= irq_request && !irq_ack;
      irq_ack <= irq_request && !irq_ack && cnt_r;
    end
  end
endmodule // pmwc_cpu_model

// >>> test/tb_power_mode_wake_controller.sv
// Testbench for the power-mode controller with a CPU model acknowledging grants.
// Assumes a 40 MHz clock and a shortened startup count.
`timescale 1ns/1ps
module tb_power_mode_wake_controller;
  localparam int SC = 8;
  logic        clk = 1'b0, rst = 1'b1, slow_sel = 1'b0, osc_ie = 1'b0, wd_opt = 1'b0;
  logic        wd_en = 1'b0, w_i = 1'b0, h_i = 1'b0, t_i = 1'b0, mclr = 1'b0;
  logic        c_psh = 1'b0, c_pop = 1'b0, c_set = 1'b0;
  logic [1:0]  div_f = 2'h0;
  logic [10:0] srcs = 11'h0;
  logic        ack, cpu_en, per_en, osc_en, stopped, mask, req, wdr, sh_tb, sh_sec;
  logic [2:0]  mode;
  logic [15:0] vec;
  int          num_errors = 0;
  int          n_compared = 0;
  always #12.5 clk = ~clk;
  pmwc_controller #(.STARTUP_CYCLES(SC)) uut (.clk(clk), .rst(rst), .slow_select(slow_sel),
    .slow_divider_field(div_f), .oscillator_irq_enable(osc_ie), .watchdog_halt_option(wd_opt),
    .watchdog_enabled(wd_en), .wait_for_irq_instr(w_i), .halt_instr(h_i), .trap_instr(t_i),
    .irq_ack(ack), .cc_push(c_psh), .cc_pop(c_pop), .cc_mask_set(c_set), .cc_mask_clr(mclr),
    .timebase_irq(srcs[0]), .clock_security_irq(srcs[1]), .ext_irq_group(srcs[5:2]),
    .periph_irq(srcs[10:6]), .cpu_clk_en(cpu_en), .periph_clk_en(per_en), .osc_enable(osc_en),
    .cpu_stopped(stopped), .power_mode(mode), .irq_mask(mask), .irq_request(req),
    .irq_vector(vec), .watchdog_reset_req(wdr), .shared_src_timebase(sh_tb),
    .shared_src_security(sh_sec));
  pmwc_cpu_model cpu (.clk(clk), .rst(rst), .irq_request(req), .irq_ack(ack));
  // ==========
  // Helpers
  task automatic give_verdict;
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Bounded wait on mode (0), grant (1) or watchdog reset (2)
  task automatic await(input int s, input logic [2:0] v);
    int k;
    for (k = 0; k < 300 && (s == 0 ? mode : s == 1 ? {2'h0, req} : {2'h0, wdr}) !== v; k++)
      step(1);
    if (k == 300) begin
      num_errors++;
      give_verdict();
    end
  endtask
  task automatic period(input bit p, input int e);
    int k;
    for (k = 0; k < 100 && (p ? per_en : cpu_en) !== 1'b1; k++) step(1);
    step(1);
    for (k = 1; k < 100 && (p ? per_en : cpu_en) !== 1'b1; k++) step(1);
    chk("clock period", 16'(e), 16'(k));
  endtask
  task automatic pulse(input int s);
    case (s)
      0: w_i = 1'b1;
      1: h_i = 1'b1;
      2: t_i = 1'b1;
      3: mclr = 1'b1;
      4: c_psh = 1'b1;
      5: c_pop = 1'b1;
      default: c_set = 1'b1;
    endcase
    step(1);
    {w_i, h_i, t_i, mclr, c_psh, c_pop, c_set} = 7'h0;
  endtask
  task automatic serve(input logic [15:0] v);
    await(1, 3'h1);
    chk("irq vector", v, vec);
    await(1, 3'h0);
    chk("mask after ack", 16'h1, mask);
  endtask
  task automatic wake_len;
    int k;
    await(0, 3'h6);
    for (k = 0; k < 100 && mode === 3'h6; k++) step(1);
    chk("startup length", 16'(2 * SC), 16'(k));
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    chk("mode", 16'h0, mode);
    chk("vector", 16'hfffe, vec);
    chk("cpu stopped", 16'h0, stopped);
    period(0, 2);
  endtask
  task automatic t_mask;
    pulse(3);
    chk("mask clear", 16'h0, mask);
    step(1);
    pulse(4);
    chk("mask on push", 16'h1, mask);
    step(1);
    pulse(5);
    chk("mask on pop", 16'h0, mask);
    step(1);
    pulse(6);
    chk("mask set", 16'h1, mask);
  endtask
  task automatic t_halt;
    srcs = 11'h7c3;
    pulse(1);
    chk("halt mode", 16'h4, mode);
    chk("mask", 16'h0, mask);
    chk("osc off", 16'h0, osc_en);
    chk("cpu stopped", 16'h1, stopped);
    step(6);
    chk("halt kept", 16'h4, mode);
    srcs = 11'h008;
    wake_len();
    serve(16'hfff4);
    srcs = 11'h0;
  endtask
  task automatic t_vectors;
    int i;
    for (i = 0; i < 11; i++) begin
      pulse(3);
      srcs = 11'h1 << i;
      serve(i < 2 ? 16'hfff8 : i < 6 ? 16'hfff6 - 16'(2 * (i - 2)) : 16'hffec - 16'(2 * (i - 6)));
      chk("shared source", 16'({i == 1, i == 0}), 16'({sh_sec, sh_tb}));
      srcs = 11'h0;
    end
    pulse(0);
    chk("wait mode", 16'h2, mode);
    srcs = 11'h010;
    serve(16'hfff2);
    srcs = 11'h064;
    pulse(2);
    serve(16'hfffc);
    pulse(3);
    serve(16'hfff6);
    srcs = 11'h0;
  endtask
  task automatic t_slow;
    int i;
    slow_sel = 1'b1;
    for (i = 0; i < 4; i++) begin
      div_f = 2'(i);
      step(40);
      chk("slow mode", 16'h1, mode);
      period(0, 4 << i);
    end
    pulse(0);
    chk("slow wait", 16'h3, mode);
    period(1, 32);
    srcs = 11'h004;
    serve(16'hfff6);
    chk("back to slow", 16'h1, mode);
    srcs = 11'h0;
    slow_sel = 1'b0;
  endtask
  task automatic t_standby;
    osc_ie = 1'b1;
    wd_en = 1'b1;
    srcs = 11'h7c0;
    pulse(1);
    step(4);
    chk("standby", 16'h5, mode);
    chk("osc", 16'h1, osc_en);
    srcs = 11'h001;
    wake_len();
    serve(16'hfff8);
    srcs = 11'h0;
    osc_ie = 1'b0;
    wd_opt = 1'b1;
    pulse(1);
    chk("watchdog reset", 16'h0, wdr);
    srcs = 11'h020;
    wake_len();
    serve(16'hfff0);
    srcs = 11'h0;
    wd_opt = 1'b0;
    pulse(1);
    await(2, 3'h1);
    rst = 1'b1;
    step(2);
    rst = 1'b0;
    step(2);
    chk("mode after reset", 16'h0, mode);
  endtask
  initial begin
    step(3);
    rst = 1'b0;
    step(2);
    t_reset();
    t_mask();
    t_halt();
    t_vectors();
    t_slow();
    t_standby();
    give_verdict();
  end
endmodule // tb_power_mode_wake_controller
bind pmwc_controller pmwc_chk chk_i (.clk(clk), .rst(rst), .wait_for_irq_instr(wait_for_irq_instr),
  .halt_instr(halt_instr), .oscillator_irq_enable(oscillator_irq_enable), .irq_ack(irq_ack),
  .ext_irq_group(ext_irq_group), .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
  .osc_enable(osc_enable), .cpu_stopped(cpu_stopped), .power_mode(power_mode),
  .irq_mask(irq_mask), .watchdog_reset_req(watchdog_reset_req));
